// ==== rtl/ea_pkg.sv ====
// Constants, field layouts and carrier structs for the effective address and program map block.
// Assumes one 50 MHz core clock and a synchronous active-low reset.
// Notes on behaviour
// - File-register direct uses a 13-bit field, reaching the lowest 8192 data bytes.
// - Working register zero is the default; result to file register or it, product excepted.
// - Operand one is always a working register; operand two register, memory or 5-bit literal.
// - Modes: direct, indirect, post-modified, pre-modified, 5-bit or 10-bit literal.
// - Register indirect uses the pointer register unmodified as effective address.
// - Post-modified uses the current pointer, then adds a constant to it.
// - Pre-modified adds a signed constant first, then uses the updated pointer.
// - Indexed mode sums pointer and base-offset register; move instructions support it.
// - Literal-offset mode sums pointer register and an instruction literal.
// - Move source and destination modes differ; one 4-bit offset field is shared.
// - Branch uses a 16-bit signed literal; interrupt hold uses a 14-bit unsigned field.
// - Program space is 24 bits, data space 16 bits; program data reachable from data.
// - Table page register sits above the 16-bit effective address, forming 24 bits.
// - Table page bit 7 selects user memory at 0, configuration memory at 1.
// - Address MSB set maps visibility page above 15 address bits, 23 bits, user only.
// - Fetch and window addresses force bit 0 low; fetch also forces bit 23 low.
// - Table operations accept unaligned addresses and may read configuration space.
// - Program counter steps by two per program word, mapping onto data word addresses.
// - Table read low gives bits 15:0, or the selected byte in byte mode.
// - Table read high gives bits 23:16 with upper byte zero; phantom byte reads zero.
// - High table read and write are the only data path to program bits 23:16.
// - The visibility window is read-only and delivers only the low 16 program bits.
// - Window mapping applies only while the visibility enable bit is set.
// - A window read stretches the instruction by one cycle for two fetches.
package ea_pkg;
	localparam int DATA_W = 16;
	localparam int PROG_W = 24;
	localparam int FILE_W = 13;
	localparam int LIT5_W = 5;
	localparam int LIT10_W = 10;
	localparam int BRANCH_W = 16;
	localparam int HOLD_W = 14;
	localparam int OFFS_W = 4;
	localparam int PAGE_W = 8;
	localparam int WIN_W = 15;
	localparam int PAGE_MSB = 7;
	localparam int WIN_EN_BIT = 2;
	localparam logic [15:0] PC_STEP = 16'h0002;
	// Register map, byte addresses on AXI4-Lite
	localparam logic [7:0] ADDR_TBLPAGE = 8'h00;
	localparam logic [7:0] ADDR_VISPAGE = 8'h04;
	localparam logic [7:0] ADDR_CORECTL = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic [15:0] CORECTL_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [3:0] {
		AM_FILE, AM_DIRECT, AM_INDIRECT, AM_POST, AM_PRE,
		AM_INDEXED, AM_LITOFF, AM_LIT5, AM_LIT10, AM_BRANCH, AM_HOLD
	} addr_mode_e;

	typedef enum logic [2:0] {
		PA_NONE, PA_FETCH, PA_TRD_LOW, PA_TRD_HIGH, PA_TWR_LOW, PA_TWR_HIGH, PA_DATA
	} prog_op_e;

	typedef struct packed {
		logic valid;
		addr_mode_e mode;
		logic [15:0] instr;
		logic [15:0] pointer_reg;
		logic [15:0] base_offset_reg;
		logic [15:0] working_reg_zero;
		logic [15:0] mod_const;
		logic dest_is_default;
		logic is_product;
	} ea_req_s;

	typedef struct packed {
		logic valid;
		logic [15:0] effective_address;
		logic ptr_we;
		logic [15:0] ptr_new;
		logic [15:0] operand;
		logic to_default;
		logic near_hit;
	} ea_rsp_s;

	typedef struct packed {
		logic valid;
		prog_op_e op;
		logic byte_mode;
		logic [15:0] effective_address;
		logic [15:0] wdata;
		logic [22:0] pc;
	} pa_req_s;

	typedef struct packed {
		logic mem_en;
		logic mem_we;
		logic [23:0] mem_addr;
		logic [23:0] mem_wdata;
		logic [2:0] mem_be;
		logic config_space;
		logic [15:0] rdata;
		logic rvalid;
		logic stall;
		logic redirected;
	} pa_rsp_s;

	typedef struct packed {
		logic [7:0] tbl_page;
		logic [7:0] vis_page;
		logic [15:0] core_control_reg;
		logic aw_seen;
		logic w_seen;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic awready;
		logic wready;
		logic arready;
		ea_rsp_s ea;
		pa_rsp_s pa;
		logic win_pend;
		pa_req_s win_req;
		logic [15:0] win_count;
	} state_s;

	// Sign-extend a short literal to data width
	function automatic logic [15:0] sext(input logic [15:0] v, input int w);
		logic [15:0] m;
		m = 16'hffff << w;
		sext = v[w-1] ? (v | m) : (v & ~m);
	endfunction

	// Program word address with the low bit forced to zero
	function automatic logic [23:0] align(input logic [23:0] a);
		align = {a[23:1], 1'b0};
	endfunction
endpackage

// ==== rtl/ea_map.sv ====
// Effective address generator and program space mapper with AXI4-Lite page registers.
// Assumes requests from core logic on aclk; program memory answers combinationally via prog_rdata.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module ea_map import ea_pkg::*; (
	input wire logic aclk, // Core clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire ea_req_s ea_req, // Address generation request
	output ea_rsp_s ea_rsp, // Address generation result
	input wire pa_req_s pa_req, // Program space access request
	input wire logic [23:0] prog_rdata, // Program memory read word
	output pa_rsp_s pa_rsp // Program memory strobes and result
);
	state_s st_r;
	state_s st_nxt;

	// Read data formatting for table reads and window reads
	function automatic logic [15:0] fmt(input prog_op_e op, input logic bm, input logic bs,
			input logic [23:0] w);
		fmt = w[15:0];
		if (op == PA_TRD_LOW && bm) begin
			fmt = {8'h00, bs ? w[15:8] : w[7:0]};
		end else if (op == PA_TRD_HIGH) begin
			fmt = (bm && bs) ? 16'h0000 : {8'h00, w[23:16]};
		end
	endfunction

	//==========================================================
	// Next state
	always_comb begin
		logic [15:0] ea;
		logic [15:0] ptr;
		logic [15:0] rv;
		logic wr_ok;
		logic [7:0] wa;
		logic [23:0] pa;
		logic bs;
		ea = '0;
		ptr = '0;
		rv = '0;
		wr_ok = 1'b0;
		wa = '0;
		pa = '0;
		bs = 1'b0;
		st_nxt = st_r;

		//==========================================================
		// AXI4-Lite write
		st_nxt.awready = !st_r.aw_seen && !st_r.bvalid;
		st_nxt.wready = !st_r.w_seen && !st_r.bvalid;
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.aw_seen = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
			st_nxt.awready = 1'b0;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.w_seen = 1'b1;
			st_nxt.w_data = s_axi_wdata;
			st_nxt.w_strb = s_axi_wstrb;
			st_nxt.wready = 1'b0;
		end
		if (st_r.aw_seen && st_r.w_seen) begin
			wa = {st_r.aw_addr[7:2], 2'b00};
			wr_ok = 1'b1;
			unique case (wa)
				ADDR_TBLPAGE: if (st_r.w_strb[0]) st_nxt.tbl_page = st_r.w_data[7:0];
				ADDR_VISPAGE: if (st_r.w_strb[0]) st_nxt.vis_page = st_r.w_data[7:0];
				ADDR_CORECTL: begin
					if (st_r.w_strb[0]) st_nxt.core_control_reg[7:0] = st_r.w_data[7:0];
					if (st_r.w_strb[1]) st_nxt.core_control_reg[15:8] = st_r.w_data[15:8];
				end
				ADDR_STATUS: wr_ok = 1'b1;
				default: wr_ok = 1'b0;
			endcase
			st_nxt.aw_seen = 1'b0;
			st_nxt.w_seen = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end

		//==========================================================
		// AXI4-Lite read
		// Ready stays low while a read answer is still standing
		st_nxt.arready = !st_r.rvalid;
		if (s_axi_arvalid && st_r.arready) begin
			st_nxt.arready = 1'b0;
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				ADDR_TBLPAGE: rv = {8'h00, st_r.tbl_page};
				ADDR_VISPAGE: rv = {8'h00, st_r.vis_page};
				ADDR_CORECTL: rv = st_r.core_control_reg;
				ADDR_STATUS: rv = {13'h0000, st_r.win_pend, st_r.pa.stall, st_r.pa.config_space};
				default: st_nxt.rresp = RESP_SLVERR;
			endcase
			st_nxt.rdata = {16'h0000, rv};
		end else if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end

		//==========================================================
		// Effective address generation
		ptr = ea_req.pointer_reg;
		st_nxt.ea.valid = ea_req.valid;
		st_nxt.ea.ptr_we = 1'b0;
		st_nxt.ea.ptr_new = ptr;
		st_nxt.ea.operand = '0;
		st_nxt.ea.near_hit = 1'b0;
		// Product writes a register pair chosen elsewhere, never the default working register
		st_nxt.ea.to_default = ea_req.dest_is_default && !ea_req.is_product;
		unique case (ea_req.mode)
			AM_FILE: begin
				ea = {3'b000, ea_req.instr[FILE_W-1:0]};
				st_nxt.ea.near_hit = 1'b1;
			end
			AM_DIRECT: st_nxt.ea.operand = ptr;
			AM_INDIRECT: ea = ptr;
			AM_POST: begin
				ea = ptr;
				st_nxt.ea.ptr_we = 1'b1;
				st_nxt.ea.ptr_new = ptr + ea_req.mod_const;
			end
			AM_PRE: begin
				ea = ptr + ea_req.mod_const;
				st_nxt.ea.ptr_we = 1'b1;
				st_nxt.ea.ptr_new = ea;
			end
			AM_INDEXED: ea = ptr + ea_req.base_offset_reg;
			AM_LITOFF: ea = ptr + sext(ea_req.instr, LIT10_W);
			AM_LIT5: st_nxt.ea.operand = {11'h000, ea_req.instr[LIT5_W-1:0]};
			AM_LIT10: st_nxt.ea.operand = {6'h00, ea_req.instr[LIT10_W-1:0]};
			AM_BRANCH: ea = ea_req.instr;
			AM_HOLD: st_nxt.ea.operand = {2'b00, ea_req.instr[HOLD_W-1:0]};
			default: ea = '0;
		endcase
		st_nxt.ea.effective_address = ea;

		//==========================================================
		// Program space mapping
		st_nxt.pa.mem_en = 1'b0;
		st_nxt.pa.mem_we = 1'b0;
		st_nxt.pa.mem_be = '0;
		st_nxt.pa.rvalid = 1'b0;
		st_nxt.pa.redirected = 1'b0;
		st_nxt.pa.stall = 1'b0;
		if (st_r.pa.mem_en && !st_r.pa.mem_we) begin
			st_nxt.pa.rvalid = !st_r.win_pend;
			st_nxt.pa.rdata = fmt(st_r.win_req.op, st_r.win_req.byte_mode,
				st_r.win_req.effective_address[0], prog_rdata);
		end
		st_nxt.win_pend = 1'b0;
		if (st_r.win_pend) begin
			// Second fetch of a window read; core sees no stall during this fetch
			st_nxt.pa.mem_en = 1'b1;
			st_nxt.pa.mem_addr = st_r.pa.mem_addr;
			st_nxt.pa.redirected = 1'b1;
			st_nxt.win_count = st_r.win_count + 16'h0001;
		end else if (pa_req.valid) begin
			bs = pa_req.effective_address[0];
			st_nxt.win_req = pa_req;
			unique case (pa_req.op)
				PA_FETCH: begin
					pa = align({1'b0, pa_req.pc});
					st_nxt.pa.mem_en = 1'b1;
				end
				PA_TRD_LOW, PA_TRD_HIGH, PA_TWR_LOW, PA_TWR_HIGH: begin
					pa = {st_r.tbl_page, pa_req.effective_address};
					st_nxt.pa.config_space = st_r.tbl_page[PAGE_MSB];
					st_nxt.pa.mem_en = 1'b1;
					st_nxt.pa.mem_we = (pa_req.op == PA_TWR_LOW) || (pa_req.op == PA_TWR_HIGH);
					if (pa_req.op == PA_TWR_HIGH) begin
						st_nxt.pa.mem_be = 3'b100;
						st_nxt.pa.mem_wdata = {pa_req.wdata[7:0], 16'h0000};
					end else if (pa_req.byte_mode) begin
						st_nxt.pa.mem_be = bs ? 3'b010 : 3'b001;
						st_nxt.pa.mem_wdata = {8'h00, pa_req.wdata[7:0], pa_req.wdata[7:0]};
					end else begin
						st_nxt.pa.mem_be = 3'b011;
						st_nxt.pa.mem_wdata = {8'h00, pa_req.wdata};
					end
				end
				PA_DATA: begin
					if (pa_req.effective_address[DATA_W-1] &&
							st_r.core_control_reg[WIN_EN_BIT]) begin
						pa = align({1'b0, st_r.vis_page,
							pa_req.effective_address[WIN_W-1:0]});
						st_nxt.pa.mem_en = 1'b1;
						st_nxt.pa.redirected = 1'b1;
						st_nxt.pa.config_space = 1'b0;
						st_nxt.win_pend = 1'b1;
						st_nxt.pa.stall = 1'b1;
					end
				end
				PA_NONE: pa = '0;
			endcase
			st_nxt.pa.mem_addr = pa;
		end

		if (!aresetn) begin
			st_nxt = '0;
			st_nxt.tbl_page = PAGE_RST;
			st_nxt.vis_page = PAGE_RST;
			st_nxt.core_control_reg = CORECTL_RST;
		end
	end

	always_ff @(posedge aclk) begin
		st_r <= st_nxt;
	end

	//==========================================================
	// Outputs
	assign s_axi_awready = st_r.awready;
	assign s_axi_wready = st_r.wready;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign ea_rsp = st_r.ea;
	assign pa_rsp = st_r.pa;

	//==========================================================
	// Checks
	chk_fetch_align: assert property (@(posedge aclk) disable iff (!aresetn)
		pa_req.valid && pa_req.op == PA_FETCH && !st_r.win_pend |=>
		pa_rsp.mem_addr[0] == 1'b0 && pa_rsp.mem_addr[23] == 1'b0)
		else $error("fetch address not aligned");
	chk_table_concat: assert property (@(posedge aclk) disable iff (!aresetn)
		pa_req.valid && pa_req.op == PA_TRD_LOW && !st_r.win_pend |=>
		pa_rsp.mem_addr == {$past(st_r.tbl_page), $past(pa_req.effective_address)})
		else $error("table address wrong");
	chk_table_space: assert property (@(posedge aclk) disable iff (!aresetn)
		pa_req.valid && pa_req.op == PA_TRD_HIGH && !st_r.win_pend |=>
		pa_rsp.config_space == $past(st_r.tbl_page[PAGE_MSB]))
		else $error("table space select wrong");
	chk_window_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		pa_req.valid && pa_req.op == PA_DATA && !st_r.win_pend &&
		!st_r.core_control_reg[WIN_EN_BIT] |=> !pa_rsp.mem_en)
		else $error("window used while disabled");
	chk_window_two_fetch: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(st_r.win_pend) |-> pa_rsp.stall ##1 pa_rsp.mem_en && !pa_rsp.stall
		##1 pa_rsp.rvalid)
		else $error("window read not two cycles");
	chk_window_readonly: assert property (@(posedge aclk) disable iff (!aresetn)
		pa_rsp.redirected |-> !pa_rsp.mem_we && pa_rsp.mem_addr[23] == 1'b0)
		else $error("window not read-only");
	// Window data must be the low word of the fetch that preceded the answer
	chk_window_low_word: assert property (@(posedge aclk) disable iff (!aresetn)
		pa_rsp.rvalid && $past(st_r.win_req.op, 1) == PA_DATA |->
		pa_rsp.rdata == $past(prog_rdata[15:0], 1))
		else $error("window data not the low program word");
	chk_table_low_word: assert property (@(posedge aclk) disable iff (!aresetn)
		pa_rsp.rvalid && $past(st_r.win_req.op, 1) == PA_TRD_LOW &&
		!$past(st_r.win_req.byte_mode, 1) |->
		pa_rsp.rdata == $past(prog_rdata[15:0], 1))
		else $error("table low word read wrong");
	chk_post_modify: assert property (@(posedge aclk) disable iff (!aresetn)
		ea_req.valid && ea_req.mode == AM_POST |=>
		ea_rsp.effective_address == $past(ea_req.pointer_reg) &&
		ea_rsp.ptr_new == $past(ea_req.pointer_reg + ea_req.mod_const))
		else $error("post-modify wrong");
	chk_pre_modify: assert property (@(posedge aclk) disable iff (!aresetn)
		ea_req.valid && ea_req.mode == AM_PRE |=>
		ea_rsp.effective_address == $past(ea_req.pointer_reg + ea_req.mod_const) &&
		ea_rsp.ptr_new == ea_rsp.effective_address && ea_rsp.ptr_we)
		else $error("pre-modify wrong");
	chk_indexed_sum: assert property (@(posedge aclk) disable iff (!aresetn)
		ea_req.valid && ea_req.mode == AM_INDEXED |=>
		ea_rsp.effective_address == $past(ea_req.pointer_reg + ea_req.base_offset_reg))
		else $error("indexed address wrong");
	chk_product_dest: assert property (@(posedge aclk) disable iff (!aresetn)
		ea_req.valid && ea_req.is_product |=> !ea_rsp.to_default)
		else $error("product result sent to default register");
	chk_file_near: assert property (@(posedge aclk) disable iff (!aresetn)
		ea_req.valid && ea_req.mode == AM_FILE |=>
		ea_rsp.effective_address[15:FILE_W] == 3'b000)
		else $error("file address outside near space");
	chk_high_phantom: assert property (@(posedge aclk) disable iff (!aresetn)
		pa_rsp.rvalid && $past(st_r.win_req.op, 1) == PA_TRD_HIGH |->
		pa_rsp.rdata[15:8] == 8'h00)
		else $error("phantom byte not zero");
	cov_window: cover property (@(posedge aclk) disable iff (!aresetn)
		pa_rsp.redirected && pa_rsp.stall);
	cov_table_cfg: cover property (@(posedge aclk) disable iff (!aresetn)
		pa_rsp.mem_en && pa_rsp.config_space);
	cov_table_write: cover property (@(posedge aclk) disable iff (!aresetn)
		pa_rsp.mem_we);
	cov_axi_write: cover property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && s_axi_bready);
endmodule

// ==== testbench/prog_mem_model.sv ====
// Program memory array model facing the address mapper.
// Assumes the mapper strobes are registered on aclk; read data returns combinationally.
`timescale 1ns/10ps
module prog_mem_model import ea_pkg::*; (
	input wire logic aclk, // Core clock
	input wire pa_rsp_s pa_rsp, // Mapper strobes
	output logic [23:0] prog_rdata // Word read back
);
	// ==========================================================
	// Storage
	logic [23:0] mem [int];
	logic [23:0] last_r = 24'h0;

	// Unwritten words follow address bits 16:1, so locations differing only above bit 16 read alike
	function automatic logic [23:0] word_at(input logic [23:0] a);
		int k;
		k = int'(a[23:1]);
		if (mem.exists(k))
			return mem[k];
		return {a[8:1] ^ 8'ha5, a[16:1] ^ 16'h3c96};
	endfunction

	// ==========================================================
	// Access
	// An idle bus shows the inverse of the last word, never a stale copy
	always_comb begin
		prog_rdata = pa_rsp.mem_en ? word_at(pa_rsp.mem_addr) : ~last_r;
	end

	always @(posedge aclk) begin
		logic [23:0] w;
		w = word_at(pa_rsp.mem_addr);
		for (int b = 0; b < 3; b++) begin
			if (pa_rsp.mem_be[b])
				w[b*8 +: 8] = pa_rsp.mem_wdata[b*8 +: 8];
		end
		if (pa_rsp.mem_en && pa_rsp.mem_we)
			mem[int'(pa_rsp.mem_addr[23:1])] = w;
		if (pa_rsp.mem_en)
			last_r <= prog_rdata;
	end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the address mapper: register bus, address modes, program map.
// Assumes ea_pkg and the program memory model are compiled first.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module testbench import ea_pkg::*; ;
	logic aclk = 1'b0;
	logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr, tp;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, q;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [23:0] prog_rdata, w;
	logic [15:0] ea, m;
	ea_req_s ea_req, prev;
	ea_rsp_s ea_rsp;
	pa_req_s pa_req;
	pa_rsp_s pa_rsp;
	int num_checks = 0;
	int n_mismatch = 0;

	always #10 aclk = ~aclk;

	ea_map DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .ea_req, .ea_rsp, .pa_req, .prog_rdata, .pa_rsp);
	prog_mem_model pmem (.aclk, .pa_rsp, .prog_rdata);

	// ==========================================================
	// Bus and request tasks
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 100);
		s_axi_bready <= 1'b0;
		`CHK("bvalid", 1'b1, s_axi_bvalid)
		`CHK("bresp", er, s_axi_bresp)
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 100);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata;
		`CHK("rvalid", 1'b1, s_axi_rvalid)
		`CHK("rresp", er, s_axi_rresp)
	endtask

	// Leaves the caller just after the edge at which the mapper's strobes appear
	task automatic pa_go(input prog_op_e op, input logic bm, input logic [15:0] a,
		input logic [15:0] wd, input logic [22:0] pc);
		@(posedge aclk);
		pa_req <= '{1'b1, op, bm, a, wd, pc};
		@(posedge aclk);
		pa_req.valid <= 1'b0;
		#1;
	endtask

	function automatic logic [15:0] rd_exp(input bit hi, input bit bm, input bit bs,
		input logic [23:0] x);
		if (!hi)
			return bm ? {8'h00, bs ? x[15:8] : x[7:0]} : x[15:0];
		return (bm && bs) ? 16'h0000 : {8'h00, x[23:16]};
	endfunction

	task automatic ea_chk(input ea_req_s r);
		logic [15:0] s;
		s = r.pointer_reg + r.mod_const;
		`CHK("ea_valid", 1'b1, ea_rsp.valid)
		case (r.mode)
		AM_FILE: begin
			`CHK("file_ea", {3'b000, r.instr[12:0]}, ea_rsp.effective_address)
			`CHK("file_dst", r.dest_is_default & ~r.is_product, ea_rsp.to_default)
			`CHK("file_near", 1'b1, ea_rsp.near_hit)
		end
		AM_DIRECT: `CHK("direct", r.pointer_reg, ea_rsp.operand)
		AM_INDIRECT: `CHK("indirect", r.pointer_reg, ea_rsp.effective_address)
		AM_POST: begin
			`CHK("post_ea", r.pointer_reg, ea_rsp.effective_address)
			`CHK("post_new", s, ea_rsp.ptr_new)
			`CHK("post_we", 1'b1, ea_rsp.ptr_we)
		end
		AM_PRE: begin
			`CHK("pre_ea", s, ea_rsp.effective_address)
			`CHK("pre_new", s, ea_rsp.ptr_new)
			`CHK("pre_we", 1'b1, ea_rsp.ptr_we)
		end
		AM_INDEXED: `CHK("indexed", r.pointer_reg + r.base_offset_reg, ea_rsp.effective_address)
		AM_LITOFF: `CHK("litoff", r.pointer_reg + {{6{r.instr[9]}}, r.instr[9:0]}, ea_rsp.effective_address)
		AM_LIT5: `CHK("lit5", {11'h0, r.instr[4:0]}, ea_rsp.operand)
		AM_LIT10: `CHK("lit10", {6'h0, r.instr[9:0]}, ea_rsp.operand)
		AM_BRANCH: `CHK("branch", r.instr, ea_rsp.effective_address)
		AM_HOLD: `CHK("hold", {2'b00, r.instr[13:0]}, ea_rsp.operand)
		default: ;
		endcase
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ==========================================================
	// Watchdog
	initial begin
		repeat (6000) @(posedge aclk);
		n_mismatch++;
		$display("CHECK FAILED watchdog expected done seen hang");
		finish_test;
	end

	// ==========================================================
	// Tests
	initial begin
		aresetn <= 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
		s_axi_wstrb <= 4'hf;
		ea_req <= '0;
		pa_req <= '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		void'($urandom(96));

		for (int k = 0; k < 3; k++) begin
			axi_rd(k == 0 ? ADDR_TBLPAGE : k == 1 ? ADDR_VISPAGE : ADDR_CORECTL, d, RESP_OKAY);
			`CHK("reset_val", 32'h0, d)
		end
		axi_rd(8'h10, d, RESP_SLVERR);
		axi_wr(8'h14, 32'h0, RESP_SLVERR);
		d = $urandom;
		axi_wr(ADDR_TBLPAGE, d, RESP_OKAY);
		axi_rd(ADDR_TBLPAGE, q, RESP_OKAY);
		`CHK("page_rw", {24'h0, d[7:0]}, q)
		$display("test registers done");

		// Back to back: each edge takes a new request and shows the last result
		for (int i = 0; i <= 44; i++) begin
			@(posedge aclk);
			prev = ea_req;
			ea_req <= (i < 44) ? ea_req_s'({1'b1, 4'(i % 11), 16'($urandom), 16'($urandom),
				16'($urandom), 16'($urandom), 16'($urandom), 2'($urandom)}) : '0;
			#1;
			if (i > 0)
				ea_chk(prev);
		end
		@(posedge aclk);
		#1;
		`CHK("ea_idle", 1'b0, ea_rsp.valid)
		$display("test address modes done");

		for (int i = 0; i < 8; i++) begin
			tp = {i[2], 7'($urandom)};
			ea = 16'($urandom);
			axi_wr(ADDR_TBLPAGE, {24'h0, tp}, RESP_OKAY);
			pa_go(i[0] ? PA_TRD_HIGH : PA_TRD_LOW, i[1], ea, 16'($urandom), 23'($urandom));
			w = pmem.word_at({tp, ea});
			`CHK("tbl_addr", {tp, ea}, pa_rsp.mem_addr)
			`CHK("tbl_space", tp[7], pa_rsp.config_space)
			@(posedge aclk);
			#1;
			`CHK("tbl_rdata", rd_exp(i[0], i[1], ea[0], w), pa_rsp.rdata)
			`CHK("tbl_rvalid", 1'b1, pa_rsp.rvalid)
		end
		for (int i = 0; i < 2; i++) begin
			ea = 16'($urandom);
			m = 16'($urandom);
			pa_go(i ? PA_TWR_HIGH : PA_TWR_LOW, 1'b0, ea, m, 23'h0);
			`CHK("twr_we", 1'b1, pa_rsp.mem_we)
			`CHK("twr_be", i ? 3'b100 : 3'b011, pa_rsp.mem_be)
			`CHK("twr_data", i ? m[7:0] : m, i ? pa_rsp.mem_wdata[23:16] : pa_rsp.mem_wdata[15:0])
		end
		pa_go(PA_TRD_HIGH, 1'b0, ea, 16'h0, 23'h0);
		@(posedge aclk);
		#1;
		`CHK("twr_back", {8'h00, m[7:0]}, pa_rsp.rdata)
		axi_rd(ADDR_STATUS, q, RESP_OKAY);
		`CHK("status", {31'h0, tp[7]}, q)
		$display("test table access done");

		repeat (4) begin
			pa_go(PA_FETCH, 1'b0, 16'h0, 16'h0, 23'($urandom));
			`CHK("fetch_addr", {1'b0, pa_req.pc[22:1], 1'b0}, pa_rsp.mem_addr)
			`CHK("fetch_we", 1'b0, pa_rsp.mem_we)
		end
		$display("test fetch done");

		tp = 8'($urandom);
		axi_wr(ADDR_VISPAGE, {24'h0, tp}, RESP_OKAY);
		axi_wr(ADDR_CORECTL, 32'h4, RESP_OKAY);
		ea = 16'($urandom) | 16'h8000;
		pa_go(PA_DATA, 1'b0, ea, 16'h0, 23'h0);
		w = pmem.word_at({1'b0, tp, ea[14:1], 1'b0});
		`CHK("win_addr", {1'b0, tp, ea[14:1], 1'b0}, pa_rsp.mem_addr)
		`CHK("win_stall", 1'b1, pa_rsp.stall)
		`CHK("win_we", 1'b0, pa_rsp.mem_we)
		@(posedge aclk);
		#1;
		`CHK("win_early", 1'b0, pa_rsp.rvalid)
		@(posedge aclk);
		#1;
		`CHK("win_rvalid", 1'b1, pa_rsp.rvalid)
		`CHK("win_rdata", w[15:0], pa_rsp.rdata)
		pa_go(PA_DATA, 1'b0, ea & 16'h7fff, 16'h0, 23'h0);
		`CHK("win_low", 1'b0, pa_rsp.mem_en)
		axi_wr(ADDR_CORECTL, 32'h0, RESP_OKAY);
		pa_go(PA_DATA, 1'b0, ea, 16'h0, 23'h0);
		`CHK("win_off", 1'b0, pa_rsp.mem_en)
		`CHK("win_redir", 1'b0, pa_rsp.redirected)
		$display("test visibility window done");
		finish_test;
	end
endmodule
